// ---- pkg/csc_pkg.sv ----
// Constants, types and register map of the clock synchronous serial channel
//
// Functional notes
// - One transfer carries exactly one 8-bit word, one bit per clock cycle.
// - Internal clock is the prescaled source divided by 2(n+1), n from 00 to FF.
// - External clock mode takes the transfer clock from the clock pin.
// - Software picks CTS gating, RTS signalling or no handshake.
// - Transmit starts only with transmit enabled, a word buffered, CTS low if used.
// - Receive starts only with receive and transmit enabled and a word buffered or a re-arm pending.
// - Select 0 raises transmit request when the word enters the shift register.
// - Select 1 raises transmit request when the shift register finishes.
// - Receive request rises when a finished word enters the receive buffer.
// - Overrun flags when the seventh bit of an unread next word arrives.
// - On overrun the buffer is undefined and the receive request is not raised.
// - Edge select 0 drives on falling, samples rising; 1 does the reverse.
// - Bit order is selectable, bit 0 first or bit 7 first.
// - Continuous receive re-arms on a receive buffer read alone.
// - Channel 2 may invert every transmitted and received data bit.
// - Channel 1 may route the clock output to either of two pins.
// - Channel 0 may take CTS and drive RTS on separate pins.
// - Transmit request selects sit in common control bits 0, 1 and control one bit 4.
// - Data output idles high, or released when open drain, before the first transfer.
// - Receive-only operation still shifts out the buffered dummy word.
package csc_pkg;

    // ==========================================================
    // Register offsets
    localparam logic [2:0] CSC_OFS_MODE = 3'h0;
    localparam logic [2:0] CSC_OFS_BRG  = 3'h1;
    localparam logic [2:0] CSC_OFS_C0   = 3'h2;
    localparam logic [2:0] CSC_OFS_C1   = 3'h3;
    localparam logic [2:0] CSC_OFS_TB   = 3'h4;
    localparam logic [2:0] CSC_OFS_RB   = 3'h5;
    localparam logic [2:0] CSC_OFS_CHANNEL_COMMON_CONTROL = 3'h6;

    // ==========================================================
    // Field positions
    localparam int CSC_MODE_CKSRC = 3;
    localparam int CSC_C0_CRS     = 2;
    localparam int CSC_C0_TXEPT   = 3;
    localparam int CSC_C0_CRD     = 4;
    localparam int CSC_C0_ODRN    = 5;
    localparam int CSC_C0_EDGE    = 6;
    localparam int CSC_C0_MSB     = 7;
    localparam int CSC_C1_TE      = 0;
    localparam int CSC_C1_TEMPTY  = 1;
    localparam int CSC_C1_RE      = 2;
    localparam int CSC_C1_RFULL   = 3;
    localparam int CSC_C1_IRS     = 4;
    localparam int CSC_C1_RRM     = 5;
    localparam int CSC_C1_INV     = 6;
    localparam int CSC_UC_RRM0    = 2;
    localparam int CSC_UC_CLKSEL  = 4;
    localparam int CSC_UC_CLKDUAL = 5;
    localparam int CSC_UC_SEPCTS  = 6;
    localparam int CSC_RB_OVR     = 12;

    // Prescaler selections
    localparam logic [1:0] CSC_PRE_DIV1  = 2'h0;
    localparam logic [1:0] CSC_PRE_DIV2  = 2'h1;
    localparam logic [1:0] CSC_PRE_DIV8  = 2'h2;
    localparam logic [1:0] CSC_PRE_DIV32 = 2'h3;

    // Bit counter values
    localparam logic [2:0] CSC_BIT_SEVENTH = 3'h6;
    localparam logic [2:0] CSC_BIT_LAST    = 3'h7;

    // ==========================================================
    // Types
    typedef enum logic [1:0] {
        CSC_ST_IDLE  = 2'h1,
        CSC_ST_SHIFT = 2'h2
    } csc_fsm_type;

    typedef struct packed {
        logic sdi;
        logic clk_a;
        logic hs_n;
        logic cts_alt_n;
    } csc_pin_in_type;

    typedef struct packed {
        logic sdo;
        logic sdo_oe;
        logic clk_a;
        logic clk_a_oe;
        logic clk_b;
        logic clk_b_oe;
        logic hs_n;
        logic hs_oe;
    } csc_pin_out_type;

    typedef struct packed {
        logic [4:0] pre;
        logic [7:0] div;
        logic       tick;
    } csc_rate_type;

    typedef struct packed {
        csc_fsm_type fsm;
        logic        ext_clk;
        logic [1:0]  presc;
        logic [7:0]  c0;
        logic [7:0]  divisor;
        logic        te;
        logic        re;
        logic        tx_empty;
        logic        rx_full;
        logic        irs_own;
        logic        rrm_own;
        logic        invert;
        logic [6:0]  channel_common_control;
        logic [7:0]  tb;
        logic [7:0]  rb;
        logic        overrun;
        logic [7:0]  tx_sh;
        logic [7:0]  rx_sh;
        logic [2:0]  bit_cnt;
        logic        sclk;
        logic        ext_prev;
        logic        sdo;
        logic        rx_on;
        logic        ovr_word;
        logic        rearm;
        logic        tx_irq;
        logic        rx_irq;
        logic [15:0] rdata;
    } csc_core_type;

    // Reset values
    localparam csc_rate_type CSC_RATE_RST = '{default: '0};
    localparam csc_core_type CSC_CORE_RST = '{fsm: CSC_ST_IDLE, tx_empty: 1'b1, sclk: 1'b1,
                                              ext_prev: 1'b1, sdo: 1'b1, default: '0};

    // Position of the bit handled at count cnt
    function automatic logic [2:0] csc_bit_pos(input logic [2:0] cnt, input logic msb);
        csc_bit_pos = msb ? (CSC_BIT_LAST - cnt) : cnt;
    endfunction : csc_bit_pos

endpackage : csc_pkg

// ---- core/csc_rate_gen.sv ----
// Internal transfer clock rate generator: prescaler plus programmable divisor
`timescale 1ns/1ps
module csc_rate_gen (
    // Clock and reset
    input  wire logic       sys_clk,
    input  wire logic       rst_n,
    // Control
    input  wire logic       run,
    input  wire logic [1:0] presc_sel,
    input  wire logic [7:0] divisor,
    // Half period pulse
    output logic            half_tick
);

    csc_pkg::csc_rate_type q_r;
    csc_pkg::csc_rate_type q_nxt;
    logic                  src_en;

    // ==========================================================
    // Prescaled source enable
    always_comb begin
        unique case (presc_sel)
            csc_pkg::CSC_PRE_DIV1:  src_en = 1'b1;
            csc_pkg::CSC_PRE_DIV2:  src_en = q_r.pre[0];
            csc_pkg::CSC_PRE_DIV8:  src_en = &q_r.pre[2:0];
            csc_pkg::CSC_PRE_DIV32: src_en = &q_r.pre;
        endcase
    end

    // Divisor counts n+1 source ticks per half period
    // divide by 2(n+1)
    always_comb begin
        q_nxt = q_r;
        q_nxt.pre = q_r.pre + 5'h01;
        q_nxt.tick = 1'b0;
        if (!run) begin
            q_nxt.div = 8'h00; // Restart the divisor; the prescaler runs free, so the first half period is whole only with CSC_PRE_DIV1
        end else if (src_en) begin
            if (q_r.div == divisor) begin
                q_nxt.div = 8'h00;
                q_nxt.tick = 1'b1;
            end else begin
                q_nxt.div = q_r.div + 8'h01;
            end
        end
    end

    // State register
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            q_r <= csc_pkg::CSC_RATE_RST;
        end else begin
            q_r <= q_nxt;
        end
    end

    assign half_tick = q_r.tick;

endmodule : csc_rate_gen

// ---- core/csc_channel.sv ----
// Clock synchronous serial channel: registers, shift engine and handshake
//
// Implementation choices: the strobed register port and the register addresses.
`timescale 1ns/1ps
module csc_channel #(
    parameter int CHAN = 0
) (
    // Clock and reset
    input  wire logic                     sys_clk,
    input  wire logic                     rst_n,
    // Register port
    input  wire logic [2:0]               reg_addr,
    input  wire logic [15:0]              reg_wdata,
    input  wire logic                     reg_wr,
    input  wire logic                     reg_rd,
    output logic [15:0]                   reg_rdata,
    // Serial pins
    input  wire csc_pkg::csc_pin_in_type  pin_in,
    output csc_pkg::csc_pin_out_type      pin_out,
    // Interrupt requests
    output logic                          tx_irq,
    output logic                          rx_irq
);

    csc_pkg::csc_core_type q_r;
    csc_pkg::csc_core_type q_nxt;

    logic       half_tick;
    logic       run_int;
    logic       idle_lvl;
    logic       msb;
    logic       irs;
    logic       cont_rx;
    logic       inv;
    logic       sep_pins;
    logic       dual_clk;
    logic       cts_n;
    logic       cts_ok;
    logic       rts_n;
    logic       clk_ok;
    logic       change_e;
    logic       sample_e;
    logic       wr_tb;
    logic       start;
    logic       start_buf;
    logic       done;
    logic [7:0] rx_word;

    // ==========================================================
    // Internal transfer clock
    assign run_int = (q_r.fsm == csc_pkg::CSC_ST_SHIFT) && !q_r.ext_clk;

    csc_rate_gen u_rate (
        .sys_clk   (sys_clk),
        .rst_n     (rst_n),
        .run       (run_int),
        .presc_sel (q_r.presc),
        .divisor   (q_r.divisor),
        .half_tick (half_tick)
    );

    // ==========================================================
    // Option decode
    // idle level from edge select
    assign idle_lvl = ~q_r.c0[csc_pkg::CSC_C0_EDGE];
    assign msb      = q_r.c0[csc_pkg::CSC_C0_MSB];
    assign irs      = (CHAN == 2) ? q_r.irs_own : q_r.channel_common_control[CHAN];
    assign cont_rx  = (CHAN == 2) ? q_r.rrm_own : q_r.channel_common_control[csc_pkg::CSC_UC_RRM0 + CHAN];
    // inversion exists on channel 2 only
    assign inv      = (CHAN == 2) && q_r.invert;
    // separate handshake pins on channel 0
    assign sep_pins = (CHAN == 0) && q_r.channel_common_control[csc_pkg::CSC_UC_SEPCTS];
    // two clock pins on channel 1
    assign dual_clk = (CHAN == 1) && q_r.channel_common_control[csc_pkg::CSC_UC_CLKDUAL];

    // Handshake: CTS gates starts, RTS tells the peer we can take a word
    // three handshake options
    assign cts_n  = sep_pins ? pin_in.cts_alt_n : pin_in.hs_n;
    assign cts_ok = q_r.c0[csc_pkg::CSC_C0_CRD] || q_r.c0[csc_pkg::CSC_C0_CRS] || !cts_n;
    assign rts_n  = ~(q_r.re && !q_r.rx_full);

    // Peer must park its clock at the idle level before we arm
    // external clock idle level
    assign clk_ok = !q_r.ext_clk || (pin_in.clk_a == idle_lvl);

    // ==========================================================
    // Clock edges: leaving idle drives, returning to idle samples
    // external and internal clock edges
    always_comb begin
        if (q_r.ext_clk) begin
            change_e = (q_r.ext_prev == idle_lvl) && (pin_in.clk_a != idle_lvl);
            sample_e = (q_r.ext_prev != idle_lvl) && (pin_in.clk_a == idle_lvl);
        end else begin
            change_e = half_tick && (q_r.sclk == idle_lvl);
            sample_e = half_tick && (q_r.sclk != idle_lvl);
        end
    end

    // Start conditions; a buffer write blocks a load in the same cycle
    // transmit start gating
    assign wr_tb     = reg_wr && (reg_addr == csc_pkg::CSC_OFS_TB);
    assign start_buf = q_r.te && !q_r.tx_empty && !wr_tb;
    assign start     = (q_r.fsm == csc_pkg::CSC_ST_IDLE) && cts_ok && clk_ok &&
                       (start_buf || (q_r.rearm && q_r.te && q_r.re));
    assign done      = (q_r.fsm == csc_pkg::CSC_ST_SHIFT) && sample_e &&
                       (q_r.bit_cnt == csc_pkg::CSC_BIT_LAST);

    // ==========================================================
    // Next state: bus first, hardware after so hardware sets win
    always_comb begin
        q_nxt = q_r;
        q_nxt.rdata = 16'h0000;
        q_nxt.tx_irq = 1'b0;
        q_nxt.rx_irq = 1'b0;
        q_nxt.ext_prev = pin_in.clk_a;
        rx_word = q_r.rx_sh;

        // Register reads: data stands for one cycle only
        if (reg_rd) begin
            unique case (reg_addr)
                csc_pkg::CSC_OFS_MODE: q_nxt.rdata[csc_pkg::CSC_MODE_CKSRC] = q_r.ext_clk;
                csc_pkg::CSC_OFS_BRG:  q_nxt.rdata[7:0] = q_r.divisor;
                csc_pkg::CSC_OFS_C0: begin
                    q_nxt.rdata[7:0] = {q_r.c0[7:4], 1'b0, q_r.c0[csc_pkg::CSC_C0_CRS], q_r.presc};
                    q_nxt.rdata[csc_pkg::CSC_C0_TXEPT] = (q_r.fsm == csc_pkg::CSC_ST_IDLE);
                end
                csc_pkg::CSC_OFS_C1: begin
                    q_nxt.rdata[csc_pkg::CSC_C1_TE] = q_r.te;
                    q_nxt.rdata[csc_pkg::CSC_C1_TEMPTY] = q_r.tx_empty;
                    q_nxt.rdata[csc_pkg::CSC_C1_RE] = q_r.re;
                    q_nxt.rdata[csc_pkg::CSC_C1_RFULL] = q_r.rx_full;
                    q_nxt.rdata[csc_pkg::CSC_C1_IRS] = q_r.irs_own;
                    q_nxt.rdata[csc_pkg::CSC_C1_RRM] = q_r.rrm_own;
                    q_nxt.rdata[csc_pkg::CSC_C1_INV] = q_r.invert;
                end
                csc_pkg::CSC_OFS_TB:   q_nxt.rdata[7:0] = q_r.tb;
                csc_pkg::CSC_OFS_RB: begin
                    q_nxt.rdata[7:0] = q_r.rb;
                    q_nxt.rdata[csc_pkg::CSC_RB_OVR] = q_r.overrun;
                    q_nxt.rx_full = 1'b0;
                    if (cont_rx) begin
                        q_nxt.rearm = 1'b1;
                    end
                end
                csc_pkg::CSC_OFS_CHANNEL_COMMON_CONTROL: q_nxt.rdata[6:0] = q_r.channel_common_control;
                default:               q_nxt.rdata = 16'h0000;
            endcase
        end

        // Register writes; unmapped offsets are ignored
        if (reg_wr) begin
            unique case (reg_addr)
                csc_pkg::CSC_OFS_MODE: q_nxt.ext_clk = reg_wdata[csc_pkg::CSC_MODE_CKSRC];
                csc_pkg::CSC_OFS_BRG:  q_nxt.divisor = reg_wdata[7:0];
                csc_pkg::CSC_OFS_C0: begin
                    q_nxt.presc = reg_wdata[1:0];
                    q_nxt.c0 = reg_wdata[7:0];
                end
                csc_pkg::CSC_OFS_C1: begin
                    q_nxt.te = reg_wdata[csc_pkg::CSC_C1_TE];
                    q_nxt.re = reg_wdata[csc_pkg::CSC_C1_RE];
                    q_nxt.irs_own = reg_wdata[csc_pkg::CSC_C1_IRS];
                    q_nxt.rrm_own = reg_wdata[csc_pkg::CSC_C1_RRM];
                    q_nxt.invert = reg_wdata[csc_pkg::CSC_C1_INV];
                    // Dropping receive enable clears a stale overrun and re-arm
                    if (!reg_wdata[csc_pkg::CSC_C1_RE]) begin
                        q_nxt.overrun = 1'b0;
                        q_nxt.rearm = 1'b0;
                    end
                end
                csc_pkg::CSC_OFS_TB: begin
                    q_nxt.tb = reg_wdata[7:0];
                    q_nxt.tx_empty = 1'b0;
                end
                csc_pkg::CSC_OFS_CHANNEL_COMMON_CONTROL: q_nxt.channel_common_control = reg_wdata[6:0];
                default:               q_nxt.channel_common_control = q_r.channel_common_control;
            endcase
        end

        // Shift engine
        unique case (q_r.fsm)
            csc_pkg::CSC_ST_IDLE: begin
                q_nxt.sclk = idle_lvl;
                if (start) begin
                    q_nxt.fsm = csc_pkg::CSC_ST_SHIFT;
                    // dummy word goes out even when only receiving
                    q_nxt.tx_sh = q_r.tb;
                    q_nxt.bit_cnt = 3'h0;
                    q_nxt.rx_on = q_r.re;
                    q_nxt.ovr_word = 1'b0;
                    q_nxt.rearm = 1'b0;
                    if (start_buf) begin
                        q_nxt.tx_empty = 1'b1;
                        q_nxt.tx_irq = !irs;
                    end
                end
            end
            csc_pkg::CSC_ST_SHIFT: begin
                if (change_e) begin
                    q_nxt.sdo = q_r.tx_sh[csc_pkg::csc_bit_pos(q_r.bit_cnt, msb)] ^ inv;
                    q_nxt.sclk = ~idle_lvl;
                end
                // sample on return to idle level
                if (sample_e) begin
                    rx_word[csc_pkg::csc_bit_pos(q_r.bit_cnt, msb)] = pin_in.sdi ^ inv;
                    q_nxt.rx_sh = rx_word;
                    q_nxt.sclk = idle_lvl;
                    q_nxt.bit_cnt = q_r.bit_cnt + 3'h1;
                    if (q_r.rx_on && q_nxt.rx_full && q_r.bit_cnt == csc_pkg::CSC_BIT_SEVENTH) begin
                        q_nxt.overrun = 1'b1;
                        q_nxt.ovr_word = 1'b1;
                    end
                end
                if (done) begin
                    q_nxt.fsm = csc_pkg::CSC_ST_IDLE;
                    q_nxt.tx_irq = irs;
                    if (q_r.rx_on) begin
                        q_nxt.rb = rx_word;
                        q_nxt.rx_full = 1'b1;
                        q_nxt.rx_irq = !q_r.ovr_word;
                    end
                end
            end
        endcase
    end

    // State register
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            q_r <= csc_pkg::CSC_CORE_RST;
        end else begin
            q_r <= q_nxt;
        end
    end

    // ==========================================================
    // Outputs
    assign reg_rdata = q_r.rdata;
    assign tx_irq    = q_r.tx_irq;
    assign rx_irq    = q_r.rx_irq;

    // Open drain only pulls low; otherwise push-pull from the flop
    // data output idles high or released until the first transfer
    assign pin_out.sdo    = q_r.c0[csc_pkg::CSC_C0_ODRN] ? 1'b0 : q_r.sdo;
    assign pin_out.sdo_oe = q_r.c0[csc_pkg::CSC_C0_ODRN] ? ~q_r.sdo : 1'b1;

    // Clock pins: released when the peer makes the clock
    // clock pin routing
    assign pin_out.clk_a    = q_r.sclk;
    assign pin_out.clk_b    = q_r.sclk;
    assign pin_out.clk_a_oe = !q_r.ext_clk && !(dual_clk && q_r.channel_common_control[csc_pkg::CSC_UC_CLKSEL]);
    assign pin_out.clk_b_oe = !q_r.ext_clk && dual_clk && q_r.channel_common_control[csc_pkg::CSC_UC_CLKSEL];

    // Shared pin is RTS output only in RTS mode, separate pins keep it driven unless handshake is off
    // separate handshake pins
    assign pin_out.hs_n  = rts_n;
    assign pin_out.hs_oe = !q_r.c0[csc_pkg::CSC_C0_CRD] && (q_r.c0[csc_pkg::CSC_C0_CRS] || sep_pins);

    // ==========================================================
    // Checks
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    chk_start_gate_tx: assert property (start && start_buf |-> q_r.te && !q_r.tx_empty && cts_ok)
        else $error("transfer started without enable, data or CTS");

    chk_rx_start_gate: assert property (start && q_r.re |=> q_r.rx_on && $past(q_r.te))
        else $error("receive armed without transmit enable");

    chk_empty_on_load: assert property (start && start_buf |=> q_r.tx_empty)
        else $error("buffer empty flag not set after load");

    chk_tx_req_load: assert property (start && start_buf && !irs |=> tx_irq ##1 !tx_irq)
        else $error("transmit request missing at load");

    chk_tx_req_done: assert property (done && irs |=> tx_irq && q_r.fsm == csc_pkg::CSC_ST_IDLE)
        else $error("transmit request missing at completion");

    chk_rx_req_full: assert property (rx_irq |-> q_r.rx_full && $past(done) && !$past(q_r.ovr_word))
        else $error("receive request without completed word");

    chk_overrun_set: assert property ($rose(q_r.overrun) |-> $past(q_r.bit_cnt) == csc_pkg::CSC_BIT_SEVENTH)
        else $error("overrun set outside the seventh bit");

    chk_bit_restart: assert property (start |=> q_r.bit_cnt == 3'h0 && q_r.fsm == csc_pkg::CSC_ST_SHIFT)
        else $error("bit counter not restarted at transfer start");

    chk_idle_high: assert property ($fell(rst_n) or q_r.sdo |-> pin_out.sdo_oe ? pin_out.sdo : 1'b1)
        else $error("data output not high or released while idle");

endmodule : csc_channel

// ---- verif/csc_peer.sv ----
// Serial peer model clocked by the channel's transfer clock
`timescale 1ns/1ps
module csc_peer (
    // Link
    input  wire logic       sclk,
    input  wire logic       sdo,
    output logic            sdi,
    // Control
    input  wire logic       clr,
    input  wire logic       edge_sel,
    input  wire logic [7:0] word,
    output logic [7:0]      got
);
    logic [2:0] cnt;
    // Clear between words; idle level changes must not count as bits
    // eight bits per word
    always @(sclk or posedge clr) begin
        if (clr) begin
            cnt <= 3'h0;
            sdi <= ~sdi; // Inverts the previous data line value on every clear event
        end else if (sclk === edge_sel) begin
            sdi <= word[cnt];
        end else begin
            got <= {sdo, got[7:1]};
            cnt <= cnt + 3'h1;
        end
    end
    initial sdi = 1'b1;
endmodule : csc_peer

// ---- verif/test_csc_channel.sv ----
// Self-checking bench for the channel built as channel 2
`timescale 1ns/1ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin num_errors++; \
    $display("wrong value at %0t: %h expected %h", $time, a, b); end end
module test_csc_channel;
    logic                     sys_clk, rst_n, reg_wr, reg_rd, cts_n, clr, sdi, e, m, v, x, xclk, pclk;
    logic [2:0]               reg_addr;
    logic [15:0]              reg_wdata, reg_rdata, d;
    logic [7:0]               seed, pw, tw, got;
    logic                     tx_irq, rx_irq;
    csc_pkg::csc_pin_in_type  pin_in;
    csc_pkg::csc_pin_out_type pin_out;
    int num_errors = 0, check_count = 0, tx_cnt = 0, rx_cnt = 0, t0, r0;
    // ==========================================
    // Design, peer and clock
    // Clock pin comes from the bench when the peer owns the clock
    assign pclk   = x ? xclk : pin_out.clk_a;
    assign pin_in = '{sdi, pclk, cts_n, cts_n};
    csc_channel #(.CHAN(2)) dut_u (.sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .pin_in(pin_in), .pin_out(pin_out), .tx_irq(tx_irq), .rx_irq(rx_irq));
    csc_peer peer_u (.sclk(pclk), .sdo(pin_out.sdo), .sdi(sdi), .clr(clr),
        .edge_sel(e), .word(pw), .got(got));
    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end
    // Pulse counters for both requests
    always @(posedge sys_clk) begin
        if (tx_irq === 1'b1) tx_cnt <= tx_cnt + 1;
        if (rx_irq === 1'b1) rx_cnt <= rx_cnt + 1;
    end
    // ==========================================
    // Helpers
    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction : lfsr
    // Word after bit order and inversion
    function automatic logic [7:0] expw(input logic [7:0] w, input logic msb, input logic inv);
        logic [7:0] r;
        r = msb ? {<<{w}} : w;
        return inv ? ~r : r;
    endfunction : expw
    task automatic wr(input logic [2:0] a, input logic [15:0] val);
        @(posedge sys_clk);
        reg_addr  <= a;
        reg_wdata <= val;
        reg_wr    <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [2:0] a);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask : rd
    // Bounded wait for a request pulse
    task automatic wait_evt(input bit rx, input int old);
        int i;
        for (i = 0; i < 4000 && (rx ? rx_cnt : tx_cnt) == old; i++) begin
            @(posedge sys_clk);
            #1;
        end
        if (i == 4000) begin
            num_errors++;
            report_and_stop();
        end
    endtask : wait_evt
    task automatic report_and_stop();
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : report_and_stop
    // ==========================================
    // Main sequence
    initial begin
        {rst_n, reg_wr, reg_rd, reg_addr, reg_wdata, e} = '0;
        {cts_n, clr, x, xclk, seed, pw} = {4'b1101, 8'h3B, 8'h00};
        repeat (16) @(posedge sys_clk);
        rst_n <= 1'b1;
        #1 `CHK(pin_out.sdo, 1'b1)
        rd(3'h3);
        `CHK(d, 16'h0002)
        rd(3'h7);
        `CHK(d, 16'h0000)
        $display("test reset done");
        // Both edges, both orders, then inverted data; IRS 0
        for (int k = 0; k < 5; k++) begin
            {m, e, v} = {k[1], k[0], k == 4};
            seed = lfsr(seed);
            tw   = seed;
            seed = lfsr(seed);
            pw   = seed;
            clr <= 1'b1;
            wr(3'h1, {14'h0, seed[1:0]});
            wr(3'h2, {8'h0, m, e, 6'h10});
            rd(3'h2);
            `CHK(pin_out.clk_a, ~e)
            clr <= 1'b0;
            wr(3'h3, {9'h0, v, 6'h05});
            {t0, r0} = {tx_cnt, rx_cnt};
            wr(3'h4, {8'h0, tw});
            wait_evt(1'b0, t0);
            `CHK(rx_cnt, r0)
            wait_evt(1'b1, r0);
            rd(3'h5);
            `CHK(d[7:0], expw(pw, m, v))
            `CHK(got, expw(tw, m, v))
            $display("test word %0d done", k);
        end
        // CTS gating, completion request, then overrun
        clr <= 1'b1;
        wr(3'h2, 16'h0000);
        wr(3'h3, 16'h0014);
        wr(3'h4, 16'h00A5);
        rd(3'h3);
        `CHK(d[1], 1'b0)
        clr <= 1'b0;
        {t0, r0} = {tx_cnt, rx_cnt};
        wr(3'h3, 16'h0015);
        repeat (40) @(posedge sys_clk);
        `CHK(tx_cnt, t0)
        cts_n <= 1'b0;
        wait_evt(1'b0, t0);
        `CHK(rx_cnt, r0 + 1)
        t0 = tx_cnt;
        wr(3'h4, 16'h005A);
        wait_evt(1'b0, t0);
        `CHK(rx_cnt, r0 + 1)
        rd(3'h5);
        `CHK(d[12], 1'b1)
        $display("test overrun done");
        // External clock: peer parks its clock high for edge select 0
        clr  <= 1'b1;
        x    <= 1'b1;
        xclk <= 1'b1;
        wr(3'h0, 16'h0008);
        wr(3'h2, 16'h0010);
        wr(3'h3, 16'h0005);
        `CHK(pin_out.hs_oe, 1'b0)
        seed = lfsr(seed);
        tw   = seed;
        seed = lfsr(seed);
        pw   = seed;
        clr <= 1'b0;
        {t0, r0} = {tx_cnt, rx_cnt};
        wr(3'h4, {8'h0, tw});
        wait_evt(1'b0, t0);
        repeat (16) begin
            repeat (4) @(posedge sys_clk);
            xclk <= ~xclk;
        end
        wait_evt(1'b1, r0);
        rd(3'h5);
        `CHK(d[7:0], pw)
        `CHK(got, tw)
        $display("test external clock done");
        report_and_stop();
    end
endmodule : test_csc_channel
